// >>> hw/wcc_top.sv
// Purpose: waveform capture command handler, subcommands 0 to 8
// Assumes: classic wishbone master; element pickups arrive asynchronously
// Notes: a command runs one cycle after the command word is written
//
// How it works
// RQ1 - subcommand 0..8: define, show, arm, disarm, headers, fetches, status
// RQ2 - with the fault recorder feature set, every subcommand is refused
// RQ3 - enabled trigger bits are ORed; any selected pickup starts a capture
// RQ4 - host puts the four password bytes first, most significant first
// RQ5 - define request carries command code 0xE0
// RQ6 - byte one bits select ground then phase overcurrent elements
// RQ7 - byte two bits select directional, 46, 27, 59, 79, 81S, 81R
// RQ8 - byte three: trip, breaker open, external input, 59G, 32P, 32N
// RQ9 - trigger byte four is reserved and selects nothing
// RQ10 - trigger position limit 255, 128, 64 or 32 by record size
// RQ11 - mode bits 1:0 give 8x8, 4x16, 2x32 or 1x64 quarter cycles
// RQ12 - mode bit 6 turns single shot capture on
// RQ13 - mode bit 7 turns append record capture on
// RQ14 - show response starts with relay status then code 0xE1
// RQ15 - show response declares nine messages
// RQ16 - show response carries fifteen unit name characters
// RQ17 - show response echoes trigger bytes, position and mode
// RQ18 - quarter cycle records of eight samples per channel
// RQ19 - seven analog channels: three currents, neutral, three voltages
// RQ20 - frames end spare plus 16-bit sum; bad sum is rejected
// RQ21 - wrong password rejects define, settings unchanged
//
// The implementer's own choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "wcc_map.svh"
`default_nettype none
module wcc_top
  import wcc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [8:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [23:0] pickup_i,
  output logic capture_start_o,
  output logic armed_o,
  output logic single_shot_o,
  output logic append_o,
  output logic [1:0] rec_layout_o,
  output logic [7:0] trig_pos_o
);

  wcc_regs_t r;
  wcc_regs_t n;

  function automatic logic [15:0] wcc_sum(input logic [26:0][7:0] b,
                                          input int cnt);
    logic [15:0] s;
    s = 16'h0000;
    for (int i = 0; i < 27; i++) begin
      if (i < cnt) begin
        s = s + {8'h00, b[i]};
      end
    end
    return s;
  endfunction

  function automatic logic [7:0] wcc_pos_max(input logic [1:0] m);
    logic [7:0] v;
    unique case (m)
      2'b00: v = `WCC_POS_MAX_8;
      2'b01: v = `WCC_POS_MAX_16;
      2'b10: v = `WCC_POS_MAX_32;
      2'b11: v = `WCC_POS_MAX_64;
    endcase
    return v;
  endfunction

  function automatic logic [31:0] wcc_wmask(input logic [31:0] o,
                                            input logic [31:0] d,
                                            input logic [3:0] s);
    logic [31:0] v;
    v = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        v[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return v;
  endfunction

  function automatic logic [23:0] wcc_sel(input logic [31:0] t);
    return t[23:0] & `WCC_TRIG_SEL_MASK;
  endfunction

  logic access;
  logic [6:0] idx;
  logic [6:0] off_req;
  logic [6:0] off_uid;
  logic [6:0] off_rsp;
  logic any_hit;
  logic [15:0] req_sum;
  logic req_sum_ok;
  logic pwd_ok;

  assign access = wb_cyc_i & wb_stb_i & ~r.ack;
  assign idx = wb_adr_i[8:2];
  assign off_req = idx - `WCC_WI_REQ;
  assign off_uid = idx - `WCC_WI_UID;
  assign off_rsp = idx - `WCC_WI_RSP;
  // pickup bit positions equal trigger byte bits 1..3
  assign any_hit = |(r.sync2 & wcc_sel(r.trig)); // RQ3
  assign req_sum = wcc_sum({96'h0, r.req}, `WCC_RQ_SUMHI);
  assign req_sum_ok = (req_sum ==
    {r.req[`WCC_RQ_SUMHI], r.req[`WCC_RQ_SUMLO]}); // RQ20
  assign pwd_ok = ({r.req[0], r.req[1], r.req[2], r.req[3]} == r.pwd); // RQ4

  always_comb begin
    logic [26:0][7:0] rb;
    rb = r.rsp;
    n = r;
    n.ack = access;
    n.cap = 1'b0;
    n.sync1 = pickup_i;
    n.sync2 = r.sync1;

    // capture start; single shot disarms on the first trigger
    if (r.armed && any_hit) begin // RQ3
      n.cap = 1'b1;
      n.hit = 1'b1;
      if (r.mode[`WCC_MODE_SINGLE]) begin // RQ12
        n.armed = 1'b0;
      end
    end

    if (access) begin
      n.dat = 32'h0000_0000;
      if (!wb_we_i) begin
        if (idx == `WCC_WI_CTRL) begin
          n.dat = {31'h0, r.fdr};
        end else if (idx == `WCC_WI_STATUS) begin
          n.dat = {18'h0, r.mode[`WCC_MODE_SINGLE],
                   r.mode[`WCC_MODE_APPEND], r.sub, r.res,
                   1'b0, r.hit, r.armed, (r.st == WCC_ST_EXEC)};
        end else if (idx == `WCC_WI_PWD) begin
          n.dat = r.pwd;
        end else if (idx == `WCC_WI_RELAY) begin
          n.dat = {24'h0, r.relay};
        end else if (idx == `WCC_WI_TRIG) begin
          n.dat = r.trig;
        end else if (idx == `WCC_WI_POSMODE) begin
          n.dat = {`WCC_CHANNELS, `WCC_SAMPLES_PER_REC,
                   r.mode, r.pos}; // RQ18 RQ19
        end else if (off_req < 7'(`WCC_REQ_BYTES)) begin
          n.dat = {24'h0, r.req[off_req[3:0]]};
        end else if (off_uid < 7'(`WCC_UID_BYTES)) begin
          n.dat = {24'h0, r.uid[off_uid[3:0]]};
        end else if (off_rsp < 7'(`WCC_RSP_BYTES)) begin
          n.dat = {24'h0, r.rsp[off_rsp[4:0]]};
        end
      end else begin
        if (idx == `WCC_WI_CTRL && wb_sel_i[0]) begin
          n.fdr = wb_dat_i[0];
        end else if (idx == `WCC_WI_CMD && wb_sel_i[0]) begin
          // a command word while one is running is dropped
          if (r.st == WCC_ST_IDLE) begin
            n.sub = wb_dat_i[3:0];
            n.res = WCC_RES_NONE;
            n.st = WCC_ST_EXEC;
          end
        end else if (idx == `WCC_WI_PWD) begin
          n.pwd = wcc_wmask(r.pwd, wb_dat_i, wb_sel_i);
        end else if (idx == `WCC_WI_RELAY && wb_sel_i[0]) begin
          n.relay = wb_dat_i[7:0];
        end else if (off_req < 7'(`WCC_REQ_BYTES) && wb_sel_i[0]) begin
          n.req[off_req[3:0]] = wb_dat_i[7:0];
        end else if (off_uid < 7'(`WCC_UID_BYTES) && wb_sel_i[0]) begin
          n.uid[off_uid[3:0]] = wb_dat_i[7:0];
        end
      end
    end

    unique case (r.st)
      WCC_ST_IDLE: begin
      end
      WCC_ST_EXEC: begin
        n.st = WCC_ST_IDLE;
        if (r.fdr) begin
          n.res = WCC_RES_UNSUP; // RQ2
        end else begin
          case (r.sub) // RQ1
            WCC_SUB_DEFINE: begin
              if (!req_sum_ok) begin
                n.res = WCC_RES_BAD_SUM; // RQ20
              end else if (!pwd_ok) begin
                n.res = WCC_RES_BAD_PWD; // RQ21
              end else if (r.req[`WCC_RQ_CODE] != `WCC_CODE_DEFINE) begin
                n.res = WCC_RES_BAD_CODE; // RQ5
              end else if (r.req[`WCC_RQ_POS] >
                           wcc_pos_max(r.req[`WCC_RQ_MODE][1:0])) begin
                n.res = WCC_RES_BAD_POS; // RQ10
              end else begin
                // byte 4 is kept for the echo only
                n.trig = {r.req[`WCC_RQ_TRIG1 + 3], r.req[`WCC_RQ_TRIG1 + 2],
                          r.req[`WCC_RQ_TRIG1 + 1],
                          r.req[`WCC_RQ_TRIG1]}; // RQ6 RQ7 RQ8 RQ9
                n.pos = r.req[`WCC_RQ_POS];
                n.mode = r.req[`WCC_RQ_MODE] & `WCC_MODE_MASK; // RQ11
                n.res = WCC_RES_OK;
              end
            end
            WCC_SUB_SHOW: begin
              rb[0] = r.relay; // RQ14
              rb[1] = `WCC_CODE_SHOW;
              rb[2] = `WCC_RSP_MSGS; // RQ15
              for (int i = 0; i < `WCC_UID_BYTES; i++) begin
                rb[`WCC_RS_UID + i] = r.uid[i]; // RQ16
              end
              for (int i = 0; i < 4; i++) begin
                rb[`WCC_RS_TRIG1 + i] = r.trig[i*8 +: 8]; // RQ17
              end
              rb[`WCC_RS_POS] = r.pos;
              rb[`WCC_RS_MODE] = r.mode;
              rb[`WCC_RS_SPARE] = 8'h00;
              {rb[`WCC_RS_SUMHI], rb[`WCC_RS_SUMLO]} =
                wcc_sum(rb, `WCC_RS_SUMHI); // RQ20
              n.rsp = rb;
              n.res = WCC_RES_OK;
            end
            WCC_SUB_ARM: begin
              n.armed = 1'b1;
              // a capture started in this very cycle (already armed) still counts as a hit; else hit clears
              n.hit = n.cap;
              n.res = WCC_RES_OK;
            end
            WCC_SUB_DISARM: begin
              n.armed = 1'b0;
              n.res = WCC_RES_OK;
            end
            WCC_SUB_ACQ: begin
              n.res = WCC_RES_OK;
            end
            WCC_SUB_HDR, WCC_SUB_FIRST, WCC_SUB_NEXT, WCC_SUB_RETX: begin
              // record data is not held by this block
              n.res = WCC_RES_NOFMT;
            end
            default: begin
              n.res = WCC_RES_BAD_SUB; // RQ1
            end
          endcase
        end
      end
      default: begin
        n.st = WCC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
      r.st <= WCC_ST_IDLE;
      r.fdr <= `WCC_FDR_RST;
      r.pwd <= `WCC_PWD_RST;
      r.mode <= `WCC_MODE_RST;
      r.pos <= `WCC_POS_RST;
    end else begin
      r <= n;
    end
  end

  assign wb_dat_o = r.dat;
  assign wb_ack_o = r.ack;
  assign capture_start_o = r.cap;
  assign armed_o = r.armed;
  assign single_shot_o = r.mode[`WCC_MODE_SINGLE]; // RQ12
  assign append_o = r.mode[`WCC_MODE_APPEND]; // RQ13
  assign rec_layout_o = r.mode[1:0]; // RQ11
  assign trig_pos_o = r.pos;

  // checks
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  logic exec_define;
  logic exec_show;
  logic sel_fire;
  assign sel_fire = r.armed && |(r.sync2 & `WCC_TRIG_SEL_MASK & r.trig[23:0]);
  assign exec_define = (r.st == WCC_ST_EXEC) && !r.fdr &&
                       (r.sub == WCC_SUB_DEFINE);
  assign exec_show = (r.st == WCC_ST_EXEC) && !r.fdr &&
                     (r.sub == WCC_SUB_SHOW);

  property p_bad_sub;
    (r.st == WCC_ST_EXEC) && !r.fdr && (r.sub > WCC_SUB_ACQ)
      |=> r.res == WCC_RES_BAD_SUB;
  endproperty
  a_bad_sub: assert property (p_bad_sub) // RQ1
    else $error("subcommand above 8 not refused");

  property p_fdr_refuse;
    (r.st == WCC_ST_EXEC) && r.fdr
      |=> r.res == WCC_RES_UNSUP && $stable(r.trig) && $stable(r.rsp);
  endproperty
  a_fdr_refuse: assert property (p_fdr_refuse) // RQ2
    else $error("command served with fault recorder feature set");

  property p_trigger;
    armed_o && (|(r.sync2 & wcc_sel(r.trig))) |=> capture_start_o;
  endproperty
  a_trigger: assert property (p_trigger) // RQ3
    else $error("selected pickup did not start a capture");

  property p_reserved;
    capture_start_o |-> $past(sel_fire);
  endproperty
  a_reserved: assert property (p_reserved) // RQ9
    else $error("capture started without a selected pickup");

  property p_bad_code;
    exec_define && req_sum_ok && pwd_ok &&
      r.req[`WCC_RQ_CODE] != `WCC_CODE_DEFINE
      |=> r.res == WCC_RES_BAD_CODE && $stable(r.mode);
  endproperty
  a_bad_code: assert property (p_bad_code) // RQ5
    else $error("define with wrong code accepted");

  property p_pos_limit;
    exec_define && req_sum_ok && pwd_ok &&
      r.req[`WCC_RQ_CODE] == `WCC_CODE_DEFINE &&
      r.req[`WCC_RQ_POS] > wcc_pos_max(r.req[`WCC_RQ_MODE][1:0])
      |=> r.res == WCC_RES_BAD_POS && $stable(trig_pos_o);
  endproperty
  a_pos_limit: assert property (p_pos_limit) // RQ10
    else $error("trigger position beyond record limit accepted");

  property p_single_shot;
    capture_start_o && single_shot_o |-> !armed_o ##1 !capture_start_o;
  endproperty
  a_single_shot: assert property (p_single_shot) // RQ12
    else $error("single shot stayed armed after capture");

  property p_show_head;
    exec_show |=> r.rsp[1] == `WCC_CODE_SHOW && r.rsp[0] == $past(r.relay);
  endproperty
  a_show_head: assert property (p_show_head) // RQ14
    else $error("show response head wrong");

  property p_show_count;
    exec_show |=> r.rsp[2] == `WCC_RSP_MSGS;
  endproperty
  a_show_count: assert property (p_show_count) // RQ15
    else $error("show response message count wrong");

  property p_show_echo;
    exec_show |=> r.rsp[`WCC_RS_POS] == trig_pos_o &&
      r.rsp[`WCC_RS_MODE] == r.mode &&
      {r.rsp[21], r.rsp[20], r.rsp[19], r.rsp[18]} == r.trig;
  endproperty
  a_show_echo: assert property (p_show_echo) // RQ17
    else $error("show response echo wrong");

  property p_rsp_sum;
    exec_show |=> {r.rsp[`WCC_RS_SUMHI], r.rsp[`WCC_RS_SUMLO]} ==
      wcc_sum(r.rsp, `WCC_RS_SUMHI);
  endproperty
  a_rsp_sum: assert property (p_rsp_sum) // RQ20
    else $error("show response checksum wrong");

  property p_bad_pwd;
    exec_define && req_sum_ok && !pwd_ok
      |=> r.res == WCC_RES_BAD_PWD && $stable(r.trig) &&
          $stable(r.pos) && $stable(r.mode);
  endproperty
  a_bad_pwd: assert property (p_bad_pwd) // RQ21
    else $error("define with wrong password changed settings");

  property p_ack_once;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("ack held longer than one cycle");

  c_define_ok: cover property (exec_define ##1 r.res == WCC_RES_OK);
  c_show: cover property (exec_show ##1 r.res == WCC_RES_OK);
  c_capture: cover property (armed_o ##[1:20] capture_start_o);
  c_pwd_reject: cover property (exec_define ##1 r.res == WCC_RES_BAD_PWD);

endmodule // wcc_top
`default_nettype wire

// >>> pkg/wcc_map.svh
// Purpose: offsets, field positions, reset values and codes of the
//          waveform capture command handler
// Assumes: byte address of a register is four times its word index
// Notes: definitions only
`ifndef WCC_MAP_SVH
`define WCC_MAP_SVH

// word indexes on the bus
`define WCC_WI_CTRL 7'h00
`define WCC_WI_CMD 7'h01
`define WCC_WI_STATUS 7'h02
`define WCC_WI_PWD 7'h03
`define WCC_WI_RELAY 7'h04
`define WCC_WI_TRIG 7'h05
`define WCC_WI_POSMODE 7'h06
`define WCC_WI_REQ 7'h10
`define WCC_WI_UID 7'h20
`define WCC_WI_RSP 7'h40

// frame sizes in bytes
`define WCC_REQ_BYTES 15
`define WCC_UID_BYTES 15
`define WCC_RSP_BYTES 27

// request byte positions (0 = msg 1/1)
`define WCC_RQ_CODE 5
`define WCC_RQ_TRIG1 6
`define WCC_RQ_POS 10
`define WCC_RQ_MODE 11
`define WCC_RQ_SUMHI 13
`define WCC_RQ_SUMLO 14

// response byte positions
`define WCC_RS_UID 3
`define WCC_RS_TRIG1 18
`define WCC_RS_POS 22
`define WCC_RS_MODE 23
`define WCC_RS_SPARE 24
`define WCC_RS_SUMHI 25
`define WCC_RS_SUMLO 26

`define WCC_CODE_DEFINE 8'hE0
`define WCC_CODE_SHOW 8'hE1
`define WCC_RSP_MSGS 8'h09

// trigger byte 3 bits 3,4 and all of byte 4 select nothing
`define WCC_TRIG_SEL_MASK 24'hE7FFFF
`define WCC_MODE_MASK 8'hC3
`define WCC_MODE_SINGLE 6
`define WCC_MODE_APPEND 7

`define WCC_POS_MAX_8 8'h20
`define WCC_POS_MAX_16 8'h40
`define WCC_POS_MAX_32 8'h80
`define WCC_POS_MAX_64 8'hFF

`define WCC_SAMPLES_PER_REC 8'h08
`define WCC_CHANNELS 8'h07

`define WCC_PWD_RST 32'h0000_0000
`define WCC_MODE_RST 8'h00
`define WCC_POS_RST 8'h00
`define WCC_FDR_RST 1'b0
`endif

// >>> pkg/wcc_pkg.sv
// Purpose: types of the waveform capture command handler
// Assumes: wcc_map.svh holds the numbers
// Notes: one packed struct carries all state
`default_nettype none
package wcc_pkg;
  typedef enum logic [1:0] {
    WCC_ST_IDLE = 2'b01,
    WCC_ST_EXEC = 2'b10
  } wcc_state_t;

  typedef enum logic [3:0] {
    WCC_SUB_DEFINE = 4'h0, WCC_SUB_SHOW = 4'h1, WCC_SUB_ARM = 4'h2,
    WCC_SUB_DISARM = 4'h3, WCC_SUB_HDR = 4'h4, WCC_SUB_FIRST = 4'h5,
    WCC_SUB_NEXT = 4'h6, WCC_SUB_RETX = 4'h7, WCC_SUB_ACQ = 4'h8
  } wcc_sub_t;

  typedef enum logic [3:0] {
    WCC_RES_NONE = 4'h0, WCC_RES_OK = 4'h1, WCC_RES_BAD_SUB = 4'h2,
    WCC_RES_UNSUP = 4'h3, WCC_RES_BAD_SUM = 4'h4, WCC_RES_BAD_PWD = 4'h5,
    WCC_RES_BAD_CODE = 4'h6, WCC_RES_BAD_POS = 4'h7, WCC_RES_NOFMT = 4'h8
  } wcc_res_t;

  typedef struct packed {
    wcc_state_t st;
    logic ack;
    logic [31:0] dat;
    logic fdr;
    logic [3:0] sub;
    wcc_res_t res;
    logic [31:0] pwd;
    logic [7:0] relay;
    logic [31:0] trig;
    logic [7:0] pos;
    logic [7:0] mode;
    logic [14:0][7:0] req;
    logic [14:0][7:0] uid;
    logic [26:0][7:0] rsp;
    logic armed;
    logic hit;
    logic cap;
    logic [23:0] sync1;
    logic [23:0] sync2;
  } wcc_regs_t;
endpackage
`default_nettype wire

// >>> test/wcc_elem_model.sv
// Purpose: protective element pickups seen by the capture handler
// Assumes: a pickup is a clean level, low while the element is quiet
// Notes: holds the asked bits for exactly len_i clock cycles
`timescale 1ns/1ps
`default_nettype none
module wcc_elem_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic go_i,
  input wire logic [23:0] bits_i,
  input wire logic [7:0] len_i,
  output logic [23:0] pickup_o
);
  logic [7:0] left_r;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      left_r <= 8'h00;
      pickup_o <= 24'h000000;
    end else if (go_i) begin
      left_r <= len_i - 8'h01;
      pickup_o <= bits_i;
    end else if (left_r != 8'h00) begin
      left_r <= left_r - 8'h01;
    end else begin
      // a dropped element reads quiet, never its last value
      pickup_o <= 24'h000000;
    end
  end
endmodule // wcc_elem_model
`default_nettype wire

// >>> test/wcc_top_test.sv
// Purpose: self-checking bench of the waveform capture command handler
// Assumes: classic wishbone, ack one cycle after a taken request
// Notes: reads queue their expectation; a monitor compares at ack
`timescale 1ns/1ps
`include "wcc_map.svh"
`default_nettype none
module wcc_top_test;
  import wcc_pkg::*;
  logic clk_sys_i, rst_n_i, cyc, stb, we, go, capture_start_o, armed_o;
  logic single_shot_o, append_o, wb_ack_o;
  logic [1:0] rec_layout_o;
  logic [7:0] trig_pos_o, len, m_pos, m_mode, rl;
  logic [8:0] adr;
  logic [31:0] wdat, wb_dat_o, m_trig, m_pwd, rnd;
  logic [23:0] pick, bits;
  logic [3:0] m_res, m_sub, sel, bsel;
  logic [15:0] sm;
  logic m_arm, m_trg, m_fdr;
  logic [31:0] exp_q[$];
  logic [8:0] adr_q[$];
  logic [7:0] rb[27];
  int miscompares, n_checks, ncap, cycles, k, n0;
  integer seed;
  wcc_top DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pickup_i(pick), .capture_start_o(capture_start_o), .armed_o(armed_o),
    .single_shot_o(single_shot_o), .append_o(append_o),
    .rec_layout_o(rec_layout_o), .trig_pos_o(trig_pos_o));
  wcc_elem_model ELEM (.clk_i(clk_sys_i), .rst_n_i(rst_n_i), .go_i(go),
    .bits_i(bits), .len_i(len), .pickup_o(pick));
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    if (miscompares == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cycles++;
    if (capture_start_o === 1'b1) ncap++;
    if (wb_ack_o === 1'b1 && we === 1'b0 && exp_q.size() > 0)
      chk($sformatf("rd_%h", adr_q.pop_front()), wb_dat_o, exp_q.pop_front());
    if (cycles == 30000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  // entered just after a rising edge; returns one idle cycle later
  task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= bsel;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    if (n >= 40) miscompares++;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic rd(input logic [8:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    adr_q.push_back(a);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic cmd(input logic [3:0] s);
    bus(1'b1, {`WCC_WI_CMD, 2'b00}, {28'h0, s});
    m_sub = s;
    if (m_fdr) m_res = 4'h3;
    else if (s > 4'h8) m_res = 4'h2;
    else if (s >= 4'h4 && s <= 4'h7) m_res = 4'h8;
    else if (s != 4'h0) m_res = 4'h1;
    if (!m_fdr && s == 4'h2) {m_arm, m_trg} = 2'b10;
    if (!m_fdr && s == 4'h3) m_arm = 1'b0;
  endtask
  task automatic check_all();
    rd({`WCC_WI_STATUS, 2'b00}, {18'h0, m_mode[6], m_mode[7], m_sub, m_res,
      1'b0, m_trg, m_arm, 1'b0});
    rd({`WCC_WI_TRIG, 2'b00}, m_trig);
    rd({`WCC_WI_POSMODE, 2'b00}, {8'h07, 8'h08, m_mode, m_pos});
    chk("layout", {30'h0, rec_layout_o}, {30'h0, m_mode[1:0]});
    chk("single", {31'h0, single_shot_o}, {31'h0, m_mode[6]});
    chk("append", {31'h0, append_o}, {31'h0, m_mode[7]});
    chk("pos", {24'h0, trig_pos_o}, {24'h0, m_pos});
    chk("armed", {31'h0, armed_o}, {31'h0, m_arm});
  endtask
  task automatic define(input logic [31:0] pw, tr, input logic [7:0] code,
    ps, md, input logic [15:0] sum_err);
    logic [7:0] b[15];
    logic [15:0] s;
    logic [7:0] mx;
    b = '{pw[31:24], pw[23:16], pw[15:8], pw[7:0], 8'h00, code, tr[7:0],
      tr[15:8], tr[23:16], tr[31:24], ps, md, 8'h00, 8'h00, 8'h00};
    s = sum_err;
    for (int i = 0; i < 13; i++) s = s + {8'h00, b[i]};
    b[13] = s[15:8];
    b[14] = s[7:0];
    for (int i = 0; i < 15; i++) bus(1'b1, 9'h040 + 9'(4 * i), {24'h0, b[i]});
    mx = (md[1:0] == 2'b00) ? 8'h20 : (md[1:0] == 2'b01) ? 8'h40 :
      (md[1:0] == 2'b10) ? 8'h80 : 8'hFF;
    cmd(4'h0);
    if (!m_fdr) begin
      if (sum_err != 16'h0) m_res = 4'h4;
      else if (pw != m_pwd) m_res = 4'h5;
      else if (code != 8'hE0) m_res = 4'h6;
      else if (ps > mx) m_res = 4'h7;
      else begin
        m_res = 4'h1;
        {m_trig, m_pos, m_mode} = {tr, ps, md & 8'hC3};
      end
    end
    check_all();
  endtask
  task automatic fire(input logic [23:0] bt, input logic [7:0] n,
    input int e);
    n0 = ncap;
    bits <= bt;
    len <= n;
    go <= 1'b1;
    @(posedge clk_sys_i);
    go <= 1'b0;
    repeat (n + 8) @(posedge clk_sys_i);
    chk("captures", ncap - n0, e);
    if (e > 0) m_trg = 1'b1;
  endtask
  initial begin
    {rst_n_i, cyc, stb, we, go, adr, wdat, bits, len, sel} = '0;
    {m_trig, m_pos, m_mode, m_pwd, m_res, m_sub, m_arm, m_trg, m_fdr} = '0;
    {miscompares, n_checks, ncap, cycles} = '0;
    seed = 16822;
    bsel = 4'hF;
    repeat (4) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    check_all();
    rd({`WCC_WI_CTRL, 2'b00}, 32'h0);
    rd(9'h1FC, 32'h0);
    m_pwd = $random(seed);
    bus(1'b1, {`WCC_WI_PWD, 2'b00}, m_pwd);
    rd({`WCC_WI_PWD, 2'b00}, m_pwd);
    // only the two low byte lanes of the password may change
    rnd = $random(seed);
    bsel = 4'h3;
    bus(1'b1, {`WCC_WI_PWD, 2'b00}, rnd);
    bsel = 4'hF;
    m_pwd[15:0] = rnd[15:0];
    rd({`WCC_WI_PWD, 2'b00}, m_pwd);
    for (int md = 0; md < 4; md++) begin
      rnd = $random(seed);
      rl = (md == 3) ? 8'hFF : 8'h20 << md;
      define(m_pwd, rnd, 8'hE0, rl, {rnd[7:2], 2'(md)}, 16'h0);
      if (md < 3) define(m_pwd, ~rnd, 8'hE0, rl + 8'h01, 8'(md), 16'h0);
    end
    define(m_pwd, 32'h0000_0001, 8'hE0, 8'h00, 8'h00, 16'h0100);
    define(m_pwd ^ 32'h1, 32'h0000_0002, 8'hE0, 8'h00, 8'h00, 16'h0);
    define(m_pwd, 32'h0000_0004, 8'hE1, 8'h00, 8'h00, 16'h0);
    bus(1'b1, {`WCC_WI_CTRL, 2'b00}, 32'h1);
    m_fdr = 1'b1;
    define(m_pwd, 32'h0000_0008, 8'hE0, 8'h00, 8'h00, 16'h0);
    for (int s = 1; s < 9; s++) begin
      cmd(4'(s));
      check_all();
    end
    bus(1'b1, {`WCC_WI_CTRL, 2'b00}, 32'h0);
    m_fdr = 1'b0;
    for (int s = 4; s < 16; s++) begin
      cmd(4'(s));
      check_all();
    end
    rnd = $random(seed);
    rl = rnd[7:0];
    bus(1'b1, {`WCC_WI_RELAY, 2'b00}, {24'h0, rl});
    rb[0] = rl;
    rb[1] = 8'hE1;
    rb[2] = 8'h09;
    for (int i = 0; i < 15; i++) begin
      rnd = $random(seed);
      rb[3 + i] = rnd[7:0];
      bus(1'b1, 9'h080 + 9'(4 * i), {24'h0, rb[3 + i]});
    end
    {rb[18], rb[19], rb[20], rb[21]} = {m_trig[7:0], m_trig[15:8],
      m_trig[23:16], m_trig[31:24]};
    {rb[22], rb[23], rb[24]} = {m_pos, m_mode, 8'h00};
    sm = 16'h0;
    for (int i = 0; i < 25; i++) sm = sm + {8'h00, rb[i]};
    {rb[25], rb[26]} = sm;
    cmd(4'h1);
    for (int i = 0; i < 27; i++)
      rd(9'h100 + 9'(4 * i), {24'h0, rb[i]});
    do k = $unsigned($random(seed)) % 24; while (k == 19 || k == 20);
    rnd = 32'hFF18_0000 | (32'h1 << k);
    define(m_pwd, rnd, 8'hE0, 8'h10, 8'h00, 16'h0);
    cmd(4'h2);
    fire(24'(1 << k), 8'h05, 5);
    fire(24'h180000, 8'h05, 0);
    check_all();
    cmd(4'h3);
    fire(24'(1 << k), 8'h04, 0);
    check_all();
    define(m_pwd, rnd, 8'hE0, 8'h10, 8'h40, 16'h0);
    cmd(4'h2);
    fire(24'(1 << k), 8'h05, 1);
    m_arm = 1'b0;
    check_all();
    // reset in mid-run brings every setting back to its reset value
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    {m_trig, m_pos, m_mode, m_res, m_sub, m_arm, m_trg, m_fdr} = '0;
    @(posedge clk_sys_i);
    check_all();
    rd({`WCC_WI_PWD, 2'b00}, 32'h0);
    rd({`WCC_WI_CTRL, 2'b00}, 32'h0);
    tally_and_finish();
  end
endmodule // wcc_top_test
`default_nettype wire
